// ---- verif/qpot_core_sva.sv ----
// Port-level checks for the quad pot serial core
`default_nettype none
module qpot_core_chk
    import qpot_pkg::*;
#(
    parameter int unsigned NV_CYCLES = 50
) (
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire logic                       i_cs_n,
    input wire logic                       i_hold_n,
    input wire logic                       i_wp_n,
    input wire logic                       o_so_oe,
    input wire logic [NUM_POTS*TAPS-1:0]   o_taps,
    input wire logic [NUM_POTS*SET_W-1:0]  o_wiper_position,
    input wire logic                       o_nv_write_pending,
    input wire logic                       o_power_up_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt_q;
    logic        armed_q = 1'b0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Taps may be unknown until the wipers are written; checks arm when the first save ends
    always_ff @(posedge i_clk) begin
        if (!i_rst && $fell(o_nv_write_pending)) begin
            armed_q <= 1'b1;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 0;
        end else if (o_nv_write_pending) begin
            cnt_q <= cnt_q + 1;
        end else begin
            cnt_q <= 0;
        end
    end
    sequence s_pend_hold;
        o_nv_write_pending [*8];
    endsequence
    chk_so_idle: assert property (i_cs_n && $past(i_cs_n) |-> !o_so_oe)
        else $error("so driven while deselected");
    chk_hold_quiet: assert property (!i_hold_n && !$past(i_hold_n) |-> !o_so_oe)
        else $error("so driven while paused");
    chk_taps_onehot: assert property (armed_q |-> $onehot(o_taps[63:0]) && $onehot(o_taps[127:64])
        && $onehot(o_taps[191:128]) && $onehot(o_taps[255:192])) else $error("taps not one-hot");
    chk_tap_decode: assert property (armed_q && $past(armed_q)
        |-> o_taps[255:192] == 64'h1 << $past(o_wiper_position[23:18])) else $error("tap decode wrong");
    chk_pend_start: assert property ($rose(o_nv_write_pending) |-> i_cs_n && $past(i_cs_n))
        else $error("save started while selected");
    chk_pend_hold: assert property ($rose(o_nv_write_pending) |-> s_pend_hold)
        else $error("pending flag too short");
    chk_pend_len: assert property ($fell(o_nv_write_pending)
        |-> cnt_q + 1 >= NV_CYCLES && cnt_q <= NV_CYCLES + 1) else $error("save length wrong");
    chk_wp_block: assert property ($rose(o_nv_write_pending) |-> i_wp_n || $past(i_wp_n, 8))
        else $error("save while protected");
    chk_rst_values: assert property (disable iff (1'b0) i_rst
        |-> o_wiper_position == '0 && !o_nv_write_pending) else $error("reset values wrong");
    chk_powerup_done: assert property (disable iff (1'b0) $fell(i_rst) |=> o_power_up_done)
        else $error("power-up load flag late");
endmodule : qpot_core_chk
bind qpot_core qpot_core_chk #(.NV_CYCLES(NV_CYCLES)) u_qpot_core_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n),
    .o_so_oe(o_so_oe), .o_taps(o_taps), .o_wiper_position(o_wiper_position),
    .o_nv_write_pending(o_nv_write_pending), .o_power_up_done(o_power_up_done));
`default_nettype wire

// ---- verif/qpot_host.sv ----
// Serial host model driving the quad pot link
`default_nettype none
module qpot_host (
    input  wire logic i_so,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_si
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Clock only runs inside a frame; select held low throughout
    task automatic frame(input logic [63:0] bits, input int n, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        o_cs_n <= 1'b0;
        #40;
        for (i = 63; i > 63 - n; i--) begin
            o_si <= bits[i];
            #15 o_sck <= 1'b1;
            rd = {rd[6:0], i_so};
            #15 o_sck <= 1'b0;
        end
        #40 o_cs_n <= 1'b1;
        o_si <= ~o_si;
        #100;
    endtask : frame
endmodule : qpot_host
`default_nettype wire

// ---- verif/quad_pot_spi_register_core_bench.sv ----
// Self-checking bench for the quad pot serial core
`default_nettype none
module quad_pot_spi_register_core_bench
    import qpot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned NV    = 50;
    localparam logic [1:0]  STRAP = 2'h2;
    localparam logic [7:0]  IDOK  = {ID_TYPE_DEFAULT, ID_MID_ZERO, STRAP};
    localparam logic [23:0] VALS  = {6'h35, 6'h25, 6'h15, 6'h05};
    logic                      clk, rst, sck, cs_n, si, hold_n, wp_n, so, so_oe, pend, pud;
    logic [1:0]                strap;
    logic [NUM_POTS*TAPS-1:0]  taps;
    logic [NUM_POTS*SET_W-1:0] nv_write_pending;
    logic [7:0]                rd;
    logic [5:0]                v;
    int                        errors, n_checks, p;
    qpot_core #(.NV_CYCLES(NV)) u_qpot_core (
        .i_clk(clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n),
        .i_wp_n(wp_n), .i_strap_addr_pins(strap), .o_so(so), .o_so_oe(so_oe), .o_taps(taps),
        .o_wiper_position(nv_write_pending), .o_nv_write_pending(pend), .o_power_up_done(pud));
    qpot_host u_qpot_host (.i_so(so_oe ? so : ~so), .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
    endtask : wclk
    task automatic cmd(input logic [7:0] id, input logic [3:0] op, input logic [1:0] r,
                       input logic [1:0] pt, input logic [47:0] tl, input int n);
        u_qpot_host.frame({id, op, r, pt, tl}, n, rd);
    endtask : cmd
    task automatic wait_idle;
        int k;
        k = 0;
        while (pend !== 1'b0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        check(pend, 1'b0);
    endtask : wait_idle
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #300_000;
        errors++;
        finish_test();
    end
    initial begin
        rst = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
        strap = STRAP;
        errors = 0;
        n_checks = 0;
        #1 rst = 1'b1;
        wclk(10);
        rst <= 1'b0;
        wclk(4);
        for (p = 0; p < 4; p++) begin
            v = {p[1:0], 4'h5};
            cmd(IDOK, OP_WR_WIPER, 2'h0, p[1:0], {2'h0, v, 40'h0}, 24);
            wclk(6);
            check(nv_write_pending[p*6+:6], v);
            check(taps[p*64+:64], 64'h1 << v);
            cmd(IDOK, OP_RD_WIPER, 2'h0, p[1:0], 48'h0, 24);
            check(rd, {2'h0, v});
        end
        cmd(IDOK, OP_GCOPY_TO_STORE, 2'h0, 2'h0, 48'h0, 16);
        cmd(IDOK, OP_RD_STATUS, 2'h0, 2'h0, 48'h0, 24);
        check(rd, 8'h01);
        wait_idle();
        cmd(IDOK, OP_RD_STATUS, 2'h0, 2'h0, 48'h0, 24);
        check(rd, 8'h00);
        for (p = 0; p < 4; p++) begin
            cmd(IDOK, OP_RD_STORE, 2'h0, p[1:0], 48'h0, 24);
            check(rd, {2'h0, p[1:0], 4'h5});
        end
        cmd(IDOK, OP_WR_STORE, 2'h3, 2'h1, {8'h2C, 40'h0}, 24);
        wclk(8);
        check(pend, 1'b1);
        wait_idle();
        cmd(IDOK, OP_RD_STORE, 2'h3, 2'h1, 48'h0, 24);
        check(rd, 8'h2C);
        cmd(IDOK, OP_COPY_TO_WIPER, 2'h3, 2'h1, 48'h0, 16);
        wclk(6);
        check(nv_write_pending[11:6], 6'h2C);
        cmd(IDOK, OP_GCOPY_TO_WIPER, 2'h0, 2'h0, 48'h0, 16);
        wclk(6);
        check(nv_write_pending, VALS);
        cmd(IDOK, OP_COPY_TO_STORE, 2'h1, 2'h2, 48'h0, 16);
        wclk(8);
        wait_idle();
        cmd(IDOK, OP_RD_STORE, 2'h1, 2'h2, 48'h0, 24);
        check(rd, 8'h25);
        cmd(IDOK, OP_INC_DEC, 2'h0, 2'h3, {48{1'b1}}, 28);
        wclk(6);
        check(nv_write_pending[23:18], 6'h3F);
        cmd(IDOK, OP_INC_DEC, 2'h0, 2'h3, 48'h0, 19);
        wclk(6);
        check(nv_write_pending[23:18], 6'h3C);
        cmd(IDOK, OP_WR_WIPER, 2'h0, 2'h3, {8'h02, 40'h0}, 24);
        cmd(IDOK, OP_INC_DEC, 2'h0, 2'h3, 48'h0, 21);
        wclk(6);
        check(nv_write_pending[23:18], 6'h00);
        cmd(IDOK ^ 8'h10, OP_WR_WIPER, 2'h0, 2'h0, {8'h3A, 40'h0}, 24);
        cmd(IDOK ^ 8'h01, OP_WR_WIPER, 2'h0, 2'h0, {8'h3A, 40'h0}, 24);
        wclk(6);
        check(nv_write_pending[5:0], 6'h05);
        @(posedge clk);
        wp_n <= 1'b0;
        cmd(IDOK, OP_WR_STORE, 2'h2, 2'h0, {8'h11, 40'h0}, 24);
        wclk(20);
        check(pend, 1'b0);
        wp_n <= 1'b1;
        cmd(IDOK, OP_WR_STORE, 2'h2, 2'h0, {8'h11, 40'h0}, 20);
        wclk(10);
        check(pend, 1'b0);
        hold_n <= 1'b0;
        wclk(3);
        check(so_oe, 1'b0);
        hold_n <= 1'b1;
        cmd(IDOK, OP_WR_WIPER, 2'h0, 2'h0, {8'h3A, 40'h0}, 24);
        wclk(6);
        rst <= 1'b1;
        wclk(2);
        check(nv_write_pending, 24'h0);
        rst <= 1'b0;
        wclk(3);
        check(nv_write_pending, VALS);
        check(pud, 1'b1);
        finish_test();
    end
endmodule : quad_pot_spi_register_core_bench
`default_nettype wire

// ---- verilog/qpot_core.sv ----
// Quad potentiometer serial slave: link logic, wiper registers, setting stores
// Overview of operation
// - Serial input sampled on serial clock rise
// - Serial output three-stated unless returning data
// - Four independent wiper position registers
// - Six-bit position decoded to sixty-four taps
// - Exactly one tap active per array
// - Write-wiper command loads wiper serially
// - Copy-to-wiper commands load wiper from store
// - Increment/decrement moves one step per event
// - Power-up loads wiper from store zero
// - Wipers volatile, restored only from store zero
// - Four six-bit stores per pot, readable/writable
// - Wiper can be copied into any store
// - Store update completes within ten milliseconds
// - Save starts at select rise after complete write
// - Write-pending flag readable by status command
// - First byte after select fall is identification
// - Upper four ID bits match type code
// - Low two ID bits match strap pins
// - Output data shifted on serial clock fall
// - Deselected output is high impedance
// - Pause suspends sequence, changed only clock low
// - Protect low blocks stores writes
`default_nettype none
module qpot_core
    import qpot_pkg::*;
#(
    parameter int unsigned        NV_CYCLES = NV_WRITE_CYCLES,
    parameter logic [3:0]         ID_TYPE   = ID_TYPE_DEFAULT
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_sck,
    input  wire logic                      i_cs_n,
    input  wire logic                      i_si,
    input  wire logic                      i_hold_n,
    input  wire logic                      i_wp_n,
    input  wire logic [1:0]                i_strap_addr_pins,
    output logic                           o_so,
    output logic                           o_so_oe,
    output logic [NUM_POTS*TAPS-1:0]       o_taps,
    output logic [NUM_POTS*SET_W-1:0]      o_wiper_position,
    output logic                           o_nv_write_pending,
    output logic                           o_power_up_done
);
    // ---------------- Link domain (serial clock) ----------------
    // Chip select acts as an asynchronous reset of the frame logic, so
    // nothing depends on clock edges outside a frame.
    logic                 hold_act;
    qpot_phase_t          phase_q;
    logic [2:0]           bit_cnt_q;
    logic [7:0]           shift_q;
    logic [3:0]           op_q;
    logic [1:0]           reg_q;
    logic [1:0]           pot_q;
    logic [7:0]           rd_byte_q;
    logic                 rd_active_q;
    logic                 so_q;
    logic                 so_en_q;
    logic                 req_tgl_q;
    logic [3:0]           req_op_q;
    logic [1:0]           req_reg_q;
    logic [1:0]           req_pot_q;
    logic [SET_W-1:0]     req_data_q;
    logic                 req_up_q;
    logic                 sv_tgl_q;
    logic [3:0]           sv_op_q;
    logic [1:0]           sv_reg_q;
    logic [1:0]           sv_pot_q;
    logic [SET_W-1:0]     sv_data_q;
    logic [7:0]           shift_nx;
    logic [SET_W-1:0]     rd_src;

    assign hold_act = ~i_hold_n;
    assign shift_nx = {shift_q[6:0], i_si};

    // Read source sampled from core state; stable while the frame holds it
    // Limitation: crosses unsynchronised, so the core must be idle during reads
    logic [NUM_POTS*NUM_STORES*SET_W-1:0] store_flat;
    logic                                  pend_q;
    always_comb begin
        rd_src = SETTING_RESET;
        unique case (op_q)
            OP_RD_WIPER:  rd_src = o_wiper_position[pot_q*SET_W +: SET_W];
            OP_RD_STORE:  rd_src = store_flat[{pot_q, reg_q}*SET_W +: SET_W];
            OP_RD_STATUS: rd_src = {5'h00, pend_q};
            default:      rd_src = SETTING_RESET;
        endcase
    end

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            phase_q     <= QPOT_ID;
            bit_cnt_q   <= 3'h0;
            shift_q     <= 8'h00;
            op_q        <= 4'h0;
            reg_q       <= 2'h0;
            pot_q       <= 2'h0;
            rd_active_q <= 1'b0;
        end else if (!hold_act) begin
            shift_q   <= shift_nx;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            unique case (phase_q)
                QPOT_ID: begin
                    if (bit_cnt_q == 3'h7) begin
                        if (shift_nx[7:4] == ID_TYPE &&
                            shift_nx[1:0] == i_strap_addr_pins) begin
                            phase_q <= QPOT_INSN;
                        end else begin
                            phase_q <= QPOT_IGN;
                        end
                    end
                end
                QPOT_INSN: begin
                    if (bit_cnt_q == 3'h7) begin
                        op_q  <= shift_nx[7:4];
                        reg_q <= shift_nx[3:2];
                        pot_q <= shift_nx[1:0];
                        unique case (shift_nx[7:4])
                            OP_RD_WIPER, OP_RD_STORE, OP_RD_STATUS: begin
                                phase_q     <= QPOT_DATA;
                                rd_active_q <= 1'b1;
                            end
                            OP_WR_WIPER, OP_WR_STORE: phase_q <= QPOT_DATA;
                            OP_INC_DEC:               phase_q <= QPOT_INC;
                            OP_COPY_TO_WIPER, OP_COPY_TO_STORE,
                            OP_GCOPY_TO_WIPER, OP_GCOPY_TO_STORE: begin
                                phase_q   <= QPOT_DONE;
                            end
                            default: phase_q <= QPOT_IGN;
                        endcase
                    end
                end
                QPOT_DATA: begin
                    if (bit_cnt_q == 3'h7) begin
                        phase_q     <= QPOT_DONE;
                        rd_active_q <= 1'b0;
                    end
                end
                QPOT_INC:  phase_q <= QPOT_INC;
                QPOT_DONE: phase_q <= QPOT_DONE;
                QPOT_IGN:  phase_q <= QPOT_IGN;
                default:   phase_q <= QPOT_IGN;
            endcase
        end
    end

    // Requests to the core domain: payload loaded and toggle flipped on the same edge
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            req_tgl_q  <= 1'b0;
            req_op_q   <= 4'h0;
            req_reg_q  <= 2'h0;
            req_pot_q  <= 2'h0;
            req_data_q <= SETTING_RESET;
            req_up_q   <= 1'b0;
        end else if (!i_cs_n && !hold_act) begin
            if (phase_q == QPOT_INSN && bit_cnt_q == 3'h7 &&
                (shift_nx[7:4] == OP_COPY_TO_WIPER || shift_nx[7:4] == OP_GCOPY_TO_WIPER)) begin
                req_op_q  <= shift_nx[7:4];
                req_reg_q <= shift_nx[3:2];
                req_pot_q <= shift_nx[1:0];
                req_tgl_q <= ~req_tgl_q;
            end else if (phase_q == QPOT_DATA && bit_cnt_q == 3'h7 && op_q == OP_WR_WIPER) begin
                req_op_q   <= op_q;
                req_pot_q  <= pot_q;
                req_data_q <= shift_nx[SET_W-1:0];
                req_tgl_q  <= ~req_tgl_q;
            end else if (phase_q == QPOT_INC) begin
                req_op_q  <= OP_INC_DEC;
                req_pot_q <= pot_q;
                // Direction rides beside the toggle; si must be steady per pulse
                req_up_q  <= i_si;
                req_tgl_q <= ~req_tgl_q;
            end
        end
    end

    // Store writes: payload outlives the frame reset, toggle marks completion
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            sv_tgl_q  <= 1'b0;
            sv_op_q   <= 4'h0;
            sv_reg_q  <= 2'h0;
            sv_pot_q  <= 2'h0;
            sv_data_q <= SETTING_RESET;
        end else if (!i_cs_n && !hold_act && bit_cnt_q == 3'h7) begin
            if (phase_q == QPOT_INSN &&
                (shift_nx[7:4] == OP_COPY_TO_STORE || shift_nx[7:4] == OP_GCOPY_TO_STORE)) begin
                sv_op_q  <= shift_nx[7:4];
                sv_reg_q <= shift_nx[3:2];
                sv_pot_q <= shift_nx[1:0];
                sv_tgl_q <= ~sv_tgl_q;
            end else if (phase_q == QPOT_DATA && op_q == OP_WR_STORE) begin
                sv_op_q   <= op_q;
                sv_reg_q  <= reg_q;
                sv_pot_q  <= pot_q;
                sv_data_q <= shift_nx[SET_W-1:0];
                sv_tgl_q  <= ~sv_tgl_q;
            end
        end
    end

    // Output changes on the falling edge; hold freezes it
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            so_q      <= 1'b0;
            so_en_q   <= 1'b0;
            rd_byte_q <= 8'h00;
        end else if (!hold_act) begin
            so_en_q <= rd_active_q;
            if (rd_active_q && bit_cnt_q == 3'h0) begin
                rd_byte_q <= {2'h0, rd_src} << 1;
                so_q      <= 1'b0;
            end else begin
                rd_byte_q <= rd_byte_q << 1;
                so_q      <= rd_byte_q[7];
            end
        end
    end
    assign o_so    = so_q;
    assign o_so_oe = so_en_q & ~i_cs_n & ~hold_act;

    // ---------------- Core domain (i_clk) ----------------
    logic                          req_s;
    logic                          req_seen_q;
    logic                          sel_s;
    logic                          sel_seen_q;
    logic                          wr_s;
    logic                          sv_seen_q;
    logic                          wp_s;
    logic [SET_W-1:0]              store_q [NUM_POTS*NUM_STORES];
    logic [SET_W-1:0]              wiper_q [NUM_POTS];
    logic                          pu_q;
    logic [$clog2(NV_CYCLES+1)-1:0] nv_cnt_q;
    logic                          save_go;
    logic                          desel_edge;

    // Select synchronised active high so its reset level matches an idle bus
    qpot_sync u_req_sync (.i_clk(i_clk), .i_rst(i_rst), .i_d(req_tgl_q), .o_q(req_s));
    qpot_sync u_cs_sync  (.i_clk(i_clk), .i_rst(i_rst), .i_d(~i_cs_n),   .o_q(sel_s));
    qpot_sync u_wr_sync  (.i_clk(i_clk), .i_rst(i_rst), .i_d(sv_tgl_q),  .o_q(wr_s));
    qpot_sync u_wp_sync  (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_wp_n),    .o_q(wp_s));

    // Save fires on select rise only if the frame completed a write
    assign desel_edge = !sel_s && sel_seen_q;
    assign save_go    = desel_edge && (wr_s != sv_seen_q) && wp_s;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            req_seen_q <= 1'b0;
            sel_seen_q <= 1'b0;
            sv_seen_q  <= 1'b0;
        end else begin
            req_seen_q <= req_s;
            sel_seen_q <= sel_s;
            // A save blocked by protect is dropped, not deferred
            if (desel_edge) begin
                sv_seen_q <= wr_s;
            end
        end
    end

    // Write-pending timer stands in for the nonvolatile write time
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            nv_cnt_q <= '0;
            pend_q   <= 1'b0;
        end else if (save_go) begin
            nv_cnt_q <= ($clog2(NV_CYCLES+1))'(NV_CYCLES - 1);
            pend_q   <= 1'b1;
        end else if (nv_cnt_q != '0) begin
            nv_cnt_q <= nv_cnt_q - 1'b1;
        end else begin
            pend_q <= 1'b0;
        end
    end
    assign o_nv_write_pending = pend_q;

    // Stores: write data captured on the last data bit, copies take the wiper at save; both become visible on save
    // Store contents are not reset, as they model nonvolatile cells.
    always_ff @(posedge i_clk) begin
        if (save_go) begin
            for (int p = 0; p < NUM_POTS; p++) begin
                if (sv_op_q == OP_WR_STORE && sv_pot_q == p[1:0]) begin
                    store_q[p*NUM_STORES + sv_reg_q] <= sv_data_q;
                end
                if ((sv_op_q == OP_COPY_TO_STORE && sv_pot_q == p[1:0]) || sv_op_q == OP_GCOPY_TO_STORE) begin
                    store_q[p*NUM_STORES + sv_reg_q] <= wiper_q[p];
                end
            end
        end
    end

    // Power-up recall runs once, one cycle after reset release
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pu_q <= 1'b0;
        end else begin
            pu_q <= 1'b1;
        end
    end
    assign o_power_up_done = pu_q;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_POTS; gp++) begin : g_pot
            for (genvar gs = 0; gs < NUM_STORES; gs++) begin : g_st
                assign store_flat[(gp*NUM_STORES+gs)*SET_W +: SET_W] = store_q[gp*NUM_STORES+gs];
            end
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    wiper_q[gp] <= SETTING_RESET;
                end else if (!pu_q) begin
                    wiper_q[gp] <= store_q[gp*NUM_STORES];
                end else if (req_s != req_seen_q) begin
                    if (req_op_q == OP_WR_WIPER && req_pot_q == gp) begin
                        wiper_q[gp] <= req_data_q;
                    end else if ((req_op_q == OP_COPY_TO_WIPER && req_pot_q == gp) ||
                                 req_op_q == OP_GCOPY_TO_WIPER) begin
                        wiper_q[gp] <= store_q[gp*NUM_STORES + req_reg_q];
                    end else if (req_op_q == OP_INC_DEC && req_pot_q == gp) begin
                        if (req_up_q && wiper_q[gp] != SETTING_MAX) begin
                            wiper_q[gp] <= wiper_q[gp] + 6'h01;
                        end else if (!req_up_q && wiper_q[gp] != SETTING_RESET) begin
                            wiper_q[gp] <= wiper_q[gp] - 6'h01;
                        end
                    end
                end
            end
            assign o_wiper_position[gp*SET_W +: SET_W] = wiper_q[gp];
            qpot_tap_decode u_dec (
                .i_clk (i_clk),
                .i_rst (i_rst),
                .i_pos (wiper_q[gp]),
                .o_taps(o_taps[gp*TAPS +: TAPS])
            );
        end
    endgenerate
endmodule : qpot_core
`default_nettype wire

// ---- verilog/qpot_pkg.sv ----
// Package: constants, opcodes and timing for the quad potentiometer serial core
`default_nettype none
package qpot_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned NV_WRITE_MS     = 10;
    // Longest time rounds down
    localparam int unsigned NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_MS;
    localparam int unsigned NUM_POTS        = 4;
    localparam int unsigned NUM_STORES      = 4;
    localparam int unsigned SET_W           = 6;
    localparam int unsigned TAPS            = 64;
    localparam int unsigned SETTING_MSB     = 5;
    localparam int unsigned SETTING_LSB     = 0;
    localparam logic [3:0]  ID_TYPE_DEFAULT = 4'hA;   // Arbitrary neutral value
    localparam logic [1:0]  ID_MID_ZERO     = 2'h0;
    localparam logic [3:0]  OP_RD_WIPER     = 4'h9;
    localparam logic [3:0]  OP_WR_WIPER     = 4'hA;
    localparam logic [3:0]  OP_RD_STORE     = 4'hB;
    localparam logic [3:0]  OP_WR_STORE     = 4'hC;
    localparam logic [3:0]  OP_COPY_TO_WIPER  = 4'hD;
    localparam logic [3:0]  OP_COPY_TO_STORE  = 4'hE;
    localparam logic [3:0]  OP_GCOPY_TO_WIPER = 4'h1;
    localparam logic [3:0]  OP_GCOPY_TO_STORE = 4'h8;
    localparam logic [3:0]  OP_INC_DEC      = 4'h2;
    localparam logic [3:0]  OP_RD_STATUS    = 4'h5;
    localparam logic [SET_W-1:0] SETTING_RESET = 6'h00;
    localparam logic [SET_W-1:0] SETTING_MAX   = 6'h3F;
    // Link-side phases
    typedef enum logic [5:0] {
        QPOT_ID   = 6'b000001,
        QPOT_INSN = 6'b000010,
        QPOT_DATA = 6'b000100,
        QPOT_INC  = 6'b001000,
        QPOT_DONE = 6'b010000,
        QPOT_IGN  = 6'b100000
    } qpot_phase_t;
endpackage : qpot_pkg
`default_nettype wire

// ---- verilog/qpot_sync.sv ----
// Two flip-flop synchroniser for a level
`default_nettype none
module qpot_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            o_q    <= 1'b0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : qpot_sync
`default_nettype wire

// ---- verilog/qpot_tap_decode.sv ----
// One-hot tap decoder for a single wiper position
`default_nettype none
module qpot_tap_decode
    import qpot_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [SET_W-1:0] i_pos,
    output logic [TAPS-1:0]       o_taps
);
    // Registered so glitches never close two switches at once
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_taps <= 64'h0000_0000_0000_0001;
        end else begin
            o_taps <= 64'h0000_0000_0000_0001 << i_pos;
        end
    end
endmodule : qpot_tap_decode
`default_nettype wire
